// ==== hdl/eba_arbiter.sv ====
// Bus mastership handshake of the external memory port
// Notes on behaviour
// RULE1 - Request is asserted while the device needs the external bus, dropped after.
// RULE2 - Reset drops the request and returns arbitration to bus slave.
// RULE3 - In stop or wait, request drops if hold bit is 0, else holds.
// RULE4 - The hold request bit forces the request on without a pending access.
// RULE5 - Only external bus needs drive the request; internal activity never does.
// RULE6 - Request may change as master or slave; parked master may drop it.
// RULE7 - The outside arbiter asserts grant to name this device next master.
// RULE8 - After grant, mastership and busy drive wait for busy deasserted.
// RULE9 - Grant removal releases mastership at the end of the current bus cycle.
// RULE10 - Asynchronous arbitration mode passes grant and busy through internal synchronisers.
// RULE11 - In that mode the arbiter spaces one grant removal from the next grant.
// RULE12 - A pending master takes the bus, then asserts busy, after busy deasserts.
// RULE13 - A master may keep busy asserted when idle and reuse the bus.
// RULE14 - Busy is released by driving it high, then tri-stating it.
// RULE15 - Grant and busy are ignored during reset; grant ignored in stop or wait.
`timescale 1ns/10ps
`include "eba_params.svh"

module eba_arbiter
    import eba_pkg::*;
#(
    parameter int RELEASE_CYCLES = `EBA_RELEASE_HIGH_CYCLES,
    parameter int EXTRA_STAGES = `EBA_ASYNC_EXTRA_STAGES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_grant_n,
    input wire logic bus_busy_n_in,
    output logic bus_busy_n_out,
    output logic bus_busy_n_oe,
    output logic bus_request_n,
    input wire logic access_req,
    input wire logic bus_cycle_active,
    input wire logic stop_wait,
    input wire logic hold_request_bit,
    input wire logic async_arbitration_enable,
    output logic bus_master
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    localparam int REL_MAX = `EBA_RELEASE_HIGH_MAX;

    if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > REL_MAX) begin : g_bad_release
        $error("eba_arbiter: RELEASE_CYCLES must be within 1 to 16");
    end

    // ------------------------------------------------------------------------
    // Conditioned pin inputs
    // ------------------------------------------------------------------------
    eba_sync_if sif ();

    eba_sync #(
        .EXTRA_STAGES(EXTRA_STAGES)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .bus_grant_n(bus_grant_n),
        .bus_busy_n_in(bus_busy_n_in),
        .async_arbitration_enable(async_arbitration_enable),
        .sif(sif)
    );

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        eba_state_t st;
        logic req_n;
        logic busy_out;
        logic busy_oe;
        logic master;
        logic [`EBA_CNT_W-1:0] cnt;
    } eba_arb_st_t;

    eba_arb_st_t s_q;
    eba_arb_st_t s_d;

    // Pin drive of a state: {busy_out, busy_oe, master}
    function automatic logic [2:0] drive_of(input eba_state_t st);
        case (st)
            EBA_MASTER: drive_of = {`EBA_LINE_ACTIVE, 1'b1, 1'b1};
            EBA_RELEASE: drive_of = {`EBA_LINE_IDLE, 1'b1, 1'b0};
            default: drive_of = {`EBA_LINE_IDLE, 1'b0, 1'b0};
        endcase
    endfunction : drive_of

    logic granted;
    logic bus_free;

    assign granted = (sif.grant_n == `EBA_LINE_ACTIVE) && !stop_wait; // RULE15
    assign bus_free = (sif.busy_n == `EBA_LINE_IDLE);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Request from external bus needs and the hold bit only
        if (stop_wait) begin
            if (!hold_request_bit) begin
                s_d.req_n = 1'b1; // RULE3
            end else begin
                s_d.req_n = s_q.req_n; // RULE3
            end
        end else begin
            s_d.req_n = ~(access_req | hold_request_bit); // RULE1 RULE4 RULE5 RULE6
        end

        case (s_q.st)
            EBA_SLAVE: begin
                if (granted) begin
                    s_d.st = EBA_WAIT_FREE; // RULE7
                end
            end
            EBA_WAIT_FREE: begin
                if (!granted) begin
                    s_d.st = EBA_SLAVE;
                end else if (bus_free) begin
                    s_d.st = EBA_MASTER; // RULE8 RULE12
                end
            end
            EBA_MASTER: begin
                // Parked while granted; leave only when grant goes and cycle ends
                if (!stop_wait && sif.grant_n == `EBA_LINE_IDLE && !bus_cycle_active) begin
                    s_d.st = EBA_RELEASE; // RULE9 RULE13
                    s_d.cnt = `EBA_CNT_W'(RELEASE_CYCLES - 1);
                end
            end
            EBA_RELEASE: begin
                if (s_q.cnt == '0) begin
                    s_d.st = EBA_SLAVE; // RULE14
                end else begin
                    s_d.cnt = s_q.cnt - `EBA_CNT_W'(1);
                end
            end
            default: begin
                s_d.st = EBA_SLAVE;
            end
        endcase

        {s_d.busy_out, s_d.busy_oe, s_d.master} = drive_of(s_d.st); // RULE12 RULE14
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.st <= EBA_SLAVE; // RULE2 RULE15
            s_q.req_n <= ~`EBA_REQ_RESET; // RULE2
            s_q.busy_out <= `EBA_LINE_IDLE;
            s_q.busy_oe <= 1'b0;
            s_q.master <= 1'b0;
            s_q.cnt <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign bus_request_n = s_q.req_n;
    assign bus_busy_n_out = s_q.busy_out;
    assign bus_busy_n_oe = s_q.busy_oe;
    assign bus_master = s_q.master;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    req_need_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        !stop_wait && access_req |=> !bus_request_n)
        else $error("request not asserted for a pending access");

    req_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        !stop_wait && !access_req && !hold_request_bit |=> bus_request_n)
        else $error("request not dropped when the bus is not needed");

    reset_slave_a: assert property (@(posedge clk) // RULE2
        !rst_n |=> bus_request_n && !bus_master && !bus_busy_n_oe)
        else $error("reset did not return to bus slave");

    stop_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        stop_wait && !hold_request_bit |=> bus_request_n)
        else $error("request not dropped in stop without hold");

    stop_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        stop_wait && hold_request_bit |=> $stable(bus_request_n))
        else $error("request changed in stop with hold");

    hold_force_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        !stop_wait && hold_request_bit |=> !bus_request_n)
        else $error("hold bit did not force the request");

    park_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        bus_master && !stop_wait && !access_req && !hold_request_bit && !sif.grant_n
        |=> bus_request_n && bus_master)
        else $error("parked master could not drop its request");

    take_free_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        $rose(bus_master) |-> $past(sif.busy_n) && !$past(sif.grant_n))
        else $error("mastership taken while busy or without grant");

    cycle_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        bus_master && bus_cycle_active |=> bus_master)
        else $error("mastership lost inside a bus cycle");

    release_go_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        bus_master && !stop_wait && sif.grant_n && !bus_cycle_active
        |=> !bus_master && bus_busy_n_oe && bus_busy_n_out)
        else $error("mastership not released after grant removal");

    master_busy_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        bus_master |-> bus_busy_n_oe && !bus_busy_n_out)
        else $error("master does not drive busy");

    park_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        bus_master && !sif.grant_n |=> bus_master)
        else $error("granted master left the bus");

    sequence drive_high_s;
        bus_busy_n_oe && bus_busy_n_out;
    endsequence

    sequence let_go_s;
        !bus_busy_n_oe;
    endsequence

    release_seq_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        $fell(bus_master) |-> drive_high_s ##[1:REL_MAX] let_go_s)
        else $error("busy not driven high before tri-state");

    no_low_release_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        $fell(bus_busy_n_oe) |-> $past(bus_busy_n_out))
        else $error("busy released from a low drive");

    stop_ignore_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        stop_wait && !bus_master && !bus_busy_n_oe |=> !bus_master)
        else $error("grant acted on during stop or wait");

    // ------------------------------------------------------------------------
    // Handshake steps
    // ------------------------------------------------------------------------
    // States seen by the step checks below
    sequence slave_granted_s;
        s_q.st == EBA_SLAVE && granted;
    endsequence

    sequence wait_free_s;
        s_q.st == EBA_WAIT_FREE;
    endsequence

    sequence release_last_s;
        s_q.st == EBA_RELEASE && s_q.cnt == '0;
    endsequence

    grant_take_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        slave_granted_s |=> wait_free_s)
        else $error("grant not taken in bus slave state");

    grant_lost_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        wait_free_s ##0 (!granted) |=> s_q.st == EBA_SLAVE)
        else $error("grant removal not seen while waiting");

    busy_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        wait_free_s ##0 (!bus_free) |=> !bus_master && !bus_busy_n_oe)
        else $error("bus taken while busy was asserted");

    free_take_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        wait_free_s ##0 (granted && bus_free) |=> bus_master && bus_busy_n_oe && !bus_busy_n_out)
        else $error("free bus not taken after grant");

    idle_float_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        !bus_master && s_q.st != EBA_RELEASE |-> !bus_busy_n_oe)
        else $error("busy driven without mastership");

    low_master_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        bus_busy_n_oe && !bus_busy_n_out |-> bus_master)
        else $error("busy driven low by a non-master");

    park_busy_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        bus_master && !sif.grant_n && !bus_cycle_active |=> !bus_busy_n_out)
        else $error("parked master released busy");

    release_span_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        s_q.st == EBA_RELEASE |-> s_q.cnt < RELEASE_CYCLES)
        else $error("release high phase too long");

    release_end_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        release_last_s |=> !bus_busy_n_oe && !bus_master)
        else $error("busy not tri-stated after high phase");

    stop_master_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        bus_master && stop_wait |=> bus_master)
        else $error("master left the bus in stop or wait");

    req_source_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        !stop_wait |=> bus_request_n == !($past(access_req) || $past(hold_request_bit)))
        else $error("request not set from external needs alone");

endmodule : eba_arbiter

// ==== hdl/eba_params.svh ====
// Constants of the external bus arbitration handshake
`ifndef EBA_PARAMS_SVH
`define EBA_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing counts, in clk cycles, and the width of the release counter
// ----------------------------------------------------------------------------
`define EBA_PIN_SYNC_STAGES 2
`define EBA_ASYNC_EXTRA_STAGES 2
`define EBA_RELEASE_HIGH_CYCLES 1
`define EBA_RELEASE_HIGH_MAX 16
`define EBA_CNT_W 4

// ----------------------------------------------------------------------------
// Idle and active levels of the active-low lines, and the reset state of the request
// ----------------------------------------------------------------------------
`define EBA_LINE_IDLE 1'b1
`define EBA_LINE_ACTIVE 1'b0
`define EBA_REQ_RESET 1'b0

`endif

// ==== hdl/eba_pkg.sv ====
// Types of the external bus arbitration handshake
package eba_pkg;

    // ------------------------------------------------------------------------
    // Arbitration states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        EBA_SLAVE = 2'b00,
        EBA_WAIT_FREE = 2'b01,
        EBA_MASTER = 2'b10,
        EBA_RELEASE = 2'b11
    } eba_state_t;

endpackage : eba_pkg

// ==== hdl/eba_sync.sv ====
// Input conditioning of the grant and busy pins
`timescale 1ns/10ps
`include "eba_params.svh"

module eba_sync
    import eba_pkg::*;
#(
    parameter int EXTRA_STAGES = `EBA_ASYNC_EXTRA_STAGES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_grant_n,
    input wire logic bus_busy_n_in,
    input wire logic async_arbitration_enable,
    eba_sync_if.src sif
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (EXTRA_STAGES < 1) begin : g_bad_stages
        $error("eba_sync: EXTRA_STAGES must be at least 1");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`EBA_PIN_SYNC_STAGES-1:0] g_pin;
        logic [`EBA_PIN_SYNC_STAGES-1:0] b_pin;
        logic [EXTRA_STAGES-1:0] g_ext;
        logic [EXTRA_STAGES-1:0] b_ext;
    } eba_sync_st_t;

    eba_sync_st_t s_q;
    eba_sync_st_t s_d;

    always_comb begin
        s_d = s_q;
        // Stage 0 feeds stage 1 only
        s_d.g_pin = {s_q.g_pin[0], bus_grant_n};
        s_d.b_pin = {s_q.b_pin[0], bus_busy_n_in};
        // Extra resynchronisation used in asynchronous arbitration mode
        s_d.g_ext = EXTRA_STAGES'({s_q.g_ext, s_q.g_pin[1]});
        s_d.b_ext = EXTRA_STAGES'({s_q.b_ext, s_q.b_pin[1]});
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Mode select
    // ------------------------------------------------------------------------
    assign sif.grant_n = async_arbitration_enable ? s_q.g_ext[EXTRA_STAGES-1] : s_q.g_pin[1]; // RULE10
    assign sif.busy_n = async_arbitration_enable ? s_q.b_ext[EXTRA_STAGES-1] : s_q.b_pin[1]; // RULE10

endmodule : eba_sync

// ==== hdl/eba_sync_if.sv ====
// Carrier of the conditioned grant and busy levels
`timescale 1ns/10ps

interface eba_sync_if;
    logic grant_n;
    logic busy_n;

    modport src (output grant_n, output busy_n);
    modport dst (input grant_n, input busy_n);
endinterface : eba_sync_if

// ==== sim/eba_arbiter_tb.sv ====
// Self-checking bench of the bus mastership handshake
`timescale 1ns/10ps

module eba_arbiter_tb;
    localparam int REL = 1;
    localparam int XST = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic give_grant = 1'b0;
    logic other_hold = 1'b0;
    logic other_oe;
    logic bus_grant_n;
    logic busy_wire;
    logic busy_out;
    logic busy_oe;
    logic bus_request_n;
    logic access_req = 1'b0;
    logic bus_cycle_active = 1'b0;
    logic stop_wait = 1'b0;
    logic hold_request_bit = 1'b0;
    logic async_en = 1'b0;
    logic bus_master;
    int miscompares = 0;
    int cmp_count = 0;

    always #4 clk = ~clk;
    // Pull-up holds the shared busy wire high when nobody drives it
    assign busy_wire = busy_oe ? busy_out : (other_oe ? 1'b0 : 1'b1);

    eba_partner #(.GAP(4)) partner (.clk(clk), .give_grant(give_grant), .other_hold(other_hold),
        .bus_grant_n(bus_grant_n), .other_busy_oe(other_oe));

    eba_arbiter #(.RELEASE_CYCLES(REL), .EXTRA_STAGES(XST)) dut (.clk(clk), .rst_n(rst_n),
        .bus_grant_n(bus_grant_n), .bus_busy_n_in(busy_wire), .bus_busy_n_out(busy_out),
        .bus_busy_n_oe(busy_oe), .bus_request_n(bus_request_n), .access_req(access_req),
        .bus_cycle_active(bus_cycle_active), .stop_wait(stop_wait),
        .hold_request_bit(hold_request_bit), .async_arbitration_enable(async_en),
        .bus_master(bus_master));

    // ------------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------------
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wait_master(input logic val, input int n);
        int i;
        i = 0;
        while (bus_master !== val && i < n) begin
            @(negedge clk);
            i++;
        end
    endtask : wait_master

    task automatic release_bus;
        give_grant = 1'b0;
        wait_master(1'b0, 12);
        cyc(3);
    endtask : release_bus

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_request;
        access_req = 1'b1;
        cyc(2);
        check(bus_request_n, 4'h0);
        access_req = 1'b0;
        cyc(2);
        check(bus_request_n, 4'h1);
        hold_request_bit = 1'b1;
        cyc(2);
        check(bus_request_n, 4'h0);
        stop_wait = 1'b1;
        cyc(3);
        check(bus_request_n, 4'h0);
        hold_request_bit = 1'b0;
        cyc(2);
        check(bus_request_n, 4'h1);
        stop_wait = 1'b0;
    endtask : t_request

    task automatic t_acquire;
        other_hold = 1'b1;
        give_grant = 1'b1;
        access_req = 1'b1;
        cyc(14);
        check(bus_master, 4'h0);
        check(busy_oe, 4'h0);
        other_hold = 1'b0;
        wait_master(1'b1, 12);
        check(bus_master, 4'h1);
        check({busy_oe, busy_out}, 4'h2);
    endtask : t_acquire

    task automatic t_park_stop;
        access_req = 1'b0;
        cyc(20);
        check({bus_master, bus_request_n, busy_wire}, 4'h6);
        stop_wait = 1'b1;
        give_grant = 1'b0;
        cyc(10);
        check(bus_master, 4'h1);
        bus_cycle_active = 1'b1;
        stop_wait = 1'b0;
        cyc(6);
        check(bus_master, 4'h1);
        bus_cycle_active = 1'b0;
        wait_master(1'b0, 8);
        check({busy_oe, busy_out, bus_master}, 4'h6);
        cyc(REL);
        check({busy_oe, busy_wire}, 4'h1);
        cyc(3);
    endtask : t_park_stop

    task automatic t_latency(input logic mode);
        int i;
        async_en = mode;
        give_grant = 1'b1;
        i = 0;
        while (bus_grant_n !== 1'b0 && i < 20) begin
            @(posedge clk);
            i++;
        end
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(bus_master, {3'h0, ~mode});
        wait_master(1'b1, 6);
        check(bus_master, 4'h1);
        release_bus();
    endtask : t_latency

    task automatic t_reset_mid;
        give_grant = 1'b1;
        access_req = 1'b1;
        wait_master(1'b1, 20);
        rst_n = 1'b0;
        cyc(3);
        check({bus_request_n, bus_master, busy_oe}, 4'h4);
        rst_n = 1'b1;
        cyc(1);
        check(bus_request_n, 4'h0);
        wait_master(1'b1, 8);
        check(bus_master, 4'h1);
    endtask : t_reset_mid

    initial begin
        give_grant = 1'b1;
        cyc(2);
        give_grant = 1'b0;
        cyc(1);
        check({bus_request_n, bus_master, busy_oe, busy_out}, 4'h9);
        rst_n = 1'b1;
        cyc(2);
        t_request();
        t_acquire();
        t_park_stop();
        t_latency(1'b0);
        t_latency(1'b1);
        async_en = 1'b0;
        t_reset_mid();
        conclude();
    end

    initial begin
        #(8 * 4000);
        miscompares++;
        conclude();
    end
endmodule : eba_arbiter_tb

// ==== sim/eba_partner.sv ====
// Model of the outside arbiter and of one other bus master
`timescale 1ns/10ps

module eba_partner #(
    parameter int GAP = 4
) (
    input wire logic clk,
    input wire logic give_grant,
    input wire logic other_hold,
    output logic bus_grant_n,
    output logic other_busy_oe
);
    logic [7:0] gap_q;

    initial begin
        bus_grant_n = 1'b1;
        other_busy_oe = 1'b0;
        gap_q = 8'hff;
    end

    // ------------------------------------------------------------------------
    // Grant with a minimum gap after each removal
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!bus_grant_n) begin
            gap_q <= 8'h00;
        end else if (gap_q != 8'hff) begin
            gap_q <= gap_q + 8'h01;
        end
        if (!give_grant) begin
            bus_grant_n <= 1'b1;
        end else if (!bus_grant_n || gap_q >= GAP) begin
            bus_grant_n <= 1'b0;
        end
        other_busy_oe <= other_hold;
    end
endmodule : eba_partner
